// ===== design/mutex_pkg.sv
// Package: register map, field layout and bus constants for the hardware mutex
// Overview of operation
// R1: Two 32-bit registers: lock word, reset indicator
// R2: Owner in 31:16, value 15:0, flag bit 0
// R3: Zero value means free, else held
// R4: Lock word reads always succeed
// R5: Write lands only if free or owner matches
// R6: Owner compare uses same write's data atomically
// R7: Master writes own id with nonzero value
// R8: Master reads back, checks owner equals own
// R9: System reset sets reset-indicator bit
// R10: Write one clears flag; zero leaves it
// R11: Reset lock value is a parameter, default zero
// R12: Reset owner parameter, needed when value nonzero
// R13: Reset owner holds lock until it releases
// R14: Processor uses its hardware id as owner
// R15: Blocking acquire retries write and read-back
// R16: Ownership check compares stored owner with own
// R17: Release writes own id with zero value
// R18: Rejected writes complete quietly; undefined bits ignored
package mutex_pkg;
    // ==========================================================
    // Register map (word index; byte address is four times it)
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] IDX_LOCK_WORD = 4'h0;
    localparam logic [ADDR_W-1:0] IDX_RESET_IND = 4'h1;
    // ==========================================================
    // Field layout
    localparam int OWNER_HI = 31;
    localparam int OWNER_LO = 16;
    localparam int VALUE_HI = 15;
    localparam int VALUE_LO = 0;
    localparam int FLAG_BIT = 0;
    localparam logic [15:0] VALUE_FREE = 16'h0000;
    localparam logic [15:0] RESET_VALUE_DEF = 16'h0000;
    localparam logic [15:0] RESET_OWNER_DEF = 16'h0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    // Host command codes
    typedef enum logic [1:0] {CMD_LOCK, CMD_TRYLOCK, CMD_UNLOCK, CMD_IS_MINE} cmd_t;
endpackage : mutex_pkg

// ===== design/mutex_if.sv
// Interface: register port between the mutex and one bus master
`timescale 1ns/1ns
interface mutex_if;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : mutex_if

// ===== design/hw_mutex.sv
// Module: hardware mutex slave with atomic test-and-set and reset indicator
`timescale 1ns/1ns
module hw_mutex
    import mutex_pkg::*;
#(
    parameter logic [15:0] RESET_VALUE = RESET_VALUE_DEF, // R11
    parameter logic [15:0] RESET_OWNER = RESET_OWNER_DEF  // R12
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // Register port
    mutex_if.dev bus,
    // Status taps
    output logic o_locked,
    output logic o_reset_flag
);
    typedef struct packed {
        logic [15:0] owner;
        logic [15:0] value;
        logic flag;
        logic [31:0] rdata;
    } state_t;
    state_t st_q;
    state_t st_d;
    logic [15:0] wr_owner;
    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        wr_owner = bus.wdata[OWNER_HI:OWNER_LO];
        if (bus.wr && bus.addr == IDX_LOCK_WORD) begin
            // Test and set judged on this very write's data R6
            if (st_q.value == VALUE_FREE || st_q.owner == wr_owner) begin // R5 R13
                st_d.owner = wr_owner;
                st_d.value = bus.wdata[VALUE_HI:VALUE_LO];
            end
            // Otherwise dropped silently; the bus never sees an error R18
        end
        if (bus.wr && bus.addr == IDX_RESET_IND && bus.wdata[FLAG_BIT]) begin
            st_d.flag = 1'b0; // R10 R18
        end
        st_d.rdata = ZERO_WORD;
        if (bus.rd) begin
            unique case (bus.addr)
                IDX_LOCK_WORD: st_d.rdata = {st_q.owner, st_q.value}; // R1 R2 R4
                IDX_RESET_IND: st_d.rdata = {31'h0000_0000, st_q.flag}; // R2
                default: st_d.rdata = ZERO_WORD;
            endcase
        end
    end
    // ==========================================================
    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q.owner <= RESET_OWNER; // R12
            st_q.value <= RESET_VALUE; // R11
            st_q.flag <= 1'b1; // R9
            st_q.rdata <= ZERO_WORD;
        end else begin
            st_q <= st_d;
        end
    end
    assign bus.rdata = st_q.rdata;
    assign o_locked = (st_q.value != VALUE_FREE); // R3
    assign o_reset_flag = st_q.flag;
endmodule : hw_mutex

// ===== design/mutex_master.sv
// Module: bus-master end that runs lock, trylock, unlock and ownership checks
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
module mutex_master
    import mutex_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // User command
    input wire logic i_start,
    input wire cmd_t i_cmd,
    input wire logic [15:0] i_cpu_id,
    input wire logic [15:0] i_value,
    // User answer
    output logic o_busy,
    output logic o_done,
    output logic o_success,
    // Register port
    mutex_if.host bus
);
    typedef enum logic [2:0] {S_IDLE, S_WRITE, S_READ, S_WAIT, S_CHECK} fsm_t;
    typedef struct packed {
        fsm_t fsm;
        cmd_t cmd;
        logic [15:0] id;
        logic [15:0] value;
        logic done;
        logic success;
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } state_t;
    state_t st_q;
    state_t st_d;
    // ==========================================================
    // Sequencer
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        st_d.wr = 1'b0;
        st_d.rd = 1'b0;
        unique case (st_q.fsm)
            S_IDLE: begin
                if (i_start) begin
                    st_d.cmd = i_cmd;
                    st_d.id = i_cpu_id; // R14
                    st_d.value = i_value;
                    st_d.fsm = (i_cmd == CMD_IS_MINE) ? S_READ : S_WRITE;
                end
            end
            S_WRITE: begin
                st_d.wr = 1'b1;
                st_d.addr = IDX_LOCK_WORD;
                if (st_q.cmd == CMD_UNLOCK) begin
                    st_d.wdata = {st_q.id, VALUE_FREE}; // R17
                    st_d.success = 1'b1;
                    st_d.done = 1'b1;
                    st_d.fsm = S_IDLE;
                end else begin
                    st_d.wdata = {st_q.id, st_q.value}; // R7
                    st_d.fsm = S_READ;
                end
            end
            S_READ: begin
                st_d.rd = 1'b1;
                st_d.addr = IDX_LOCK_WORD;
                st_d.fsm = S_WAIT;
            end
            S_WAIT: st_d.fsm = S_CHECK;
            S_CHECK: begin
                // Owner match with a nonzero value decides; a free word is never ours
                if (bus.rdata[OWNER_HI:OWNER_LO] == st_q.id
                        && bus.rdata[VALUE_HI:VALUE_LO] != VALUE_FREE) begin // R8 R16 R3
                    st_d.success = 1'b1;
                    st_d.done = 1'b1;
                    st_d.fsm = S_IDLE;
                end else if (st_q.cmd == CMD_LOCK) begin
                    st_d.fsm = S_WRITE; // R15
                end else begin
                    st_d.success = 1'b0;
                    st_d.done = 1'b1;
                    st_d.fsm = S_IDLE;
                end
            end
            default: st_d.fsm = S_IDLE;
        endcase
    end
    // ==========================================================
    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign bus.addr = st_q.addr;
    assign bus.wdata = st_q.wdata;
    assign bus.wr = st_q.wr;
    assign bus.rd = st_q.rd;
    assign o_busy = (st_q.fsm != S_IDLE);
    assign o_done = st_q.done;
    assign o_success = st_q.success;
endmodule : mutex_master

// ===== dv/mutex_props.sv
// Checker: relations on the link between the master and the mutex
`timescale 1ns/1ns
module mutex_props
    import mutex_pkg::*;
(
    // Link and taps
    input wire logic i_ref_clk, i_srst, wr, rd, o_locked, o_reset_flag,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata, rdata
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // ==========================================
    // Shadow lock word, judged by the test-and-set rule
    logic [31:0] lock_q;
    logic take;
    assign take = wr && addr == IDX_LOCK_WORD
        && (lock_q[15:0] == VALUE_FREE || lock_q[31:16] == wdata[31:16]);
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) lock_q <= {RESET_OWNER_DEF, RESET_VALUE_DEF};
        else if (take) lock_q <= wdata;
    end
    chk_read_lock: assert property (rd && addr == 4'h0 |=> rdata == $past(lock_q))
        else $error("lock read");
    chk_read_idle: assert property (!rd |=> rdata == 32'h0) else $error("idle rdata");
    chk_locked_tap: assert property (o_locked == (lock_q[15:0] != 16'h0))
        else $error("locked");
    chk_reject_keep: assert property (wr && !take |=> $stable(o_locked))
        else $error("reject");
    chk_flag_kept: assert property (!wr |=> $stable(o_reset_flag)) else $error("flag");
    chk_no_overlap: assert property (!(wr && rd)) else $error("overlap");
    chk_read_gap: assert property (rd |=> !rd && !wr) else $error("gap");
    chk_lock_index: assert property (wr || rd |-> addr == 4'h0) else $error("index");
    cover property (wr && !take);
    cover property (take && wdata[15:0] == 16'h0);
    cover property (rd ##1 rdata != 32'h0);
endmodule : mutex_props

// ===== dv/tb_top.sv
// Testbench: master and mutex on one link, a second mutex driven directly
`timescale 1ns/1ns
module tb_top;
    import mutex_pkg::*;
    logic i_ref_clk = 1'b0, i_srst = 1'b1, i_start = 1'b0;
    cmd_t i_cmd = CMD_LOCK;
    logic [15:0] i_cpu_id = 16'h0, i_value = 16'h0;
    logic o_busy, o_done, o_success, o_locked, o_reset_flag, b_locked, b_flag;
    int errors = 0, n_compared = 0;
    mutex_if link(), side();
    // Command, id, value, success, success checked, locked
    localparam logic [36:0] CMDS [6] = '{{CMD_LOCK, 16'h1, 16'h3, 3'h7},
        {CMD_TRYLOCK, 16'h2, 16'h7, 3'h3}, {CMD_IS_MINE, 16'h1, 16'h0, 3'h7},
        {CMD_UNLOCK, 16'h2, 16'h0, 3'h1}, {CMD_UNLOCK, 16'h1, 16'h0, 3'h0},
        {CMD_TRYLOCK, 16'h2, 16'h4, 3'h7}};
    // Write flag and index, write data, read index, expected read
    localparam logic [72:0] BUS [5] = '{{5'h10, 32'hb0_0001, 4'h0, 32'ha0_0005},
        {5'h00, 32'h0, 4'h2, 32'h0}, {5'h11, 32'hffff_fffe, 4'h1, 32'h1},
        {5'h11, 32'h1, 4'h1, 32'h0}, {5'h10, 32'ha0_0000, 4'h0, 32'ha0_0000}};
    mutex_master mutex_master_inst (.i_ref_clk, .i_srst, .i_start, .i_cmd, .i_cpu_id,
        .i_value, .o_busy, .o_done, .o_success, .bus(link.host));
    hw_mutex hw_mutex_inst (.i_ref_clk, .i_srst, .bus(link.dev), .o_locked, .o_reset_flag);
    hw_mutex #(.RESET_VALUE(16'h5), .RESET_OWNER(16'ha0)) hw_mutex_b_inst (.i_ref_clk,
        .i_srst, .bus(side.dev), .o_locked(b_locked), .o_reset_flag(b_flag));
    mutex_props mutex_props_inst (.i_ref_clk, .i_srst, .wr(link.wr), .rd(link.rd), .o_locked,
        .o_reset_flag, .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata));
    initial forever #4 i_ref_clk = ~i_ref_clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic run(input logic [36:0] r);
        @(posedge i_ref_clk);
        {i_start, i_cpu_id, i_value} <= {1'b1, r[34:3]};
        i_cmd <= cmd_t'(r[36:35]);
        @(posedge i_ref_clk);
        i_start <= 1'b0;
        #1 cmp(o_busy, 1'b1);
        for (int k = 0; k < 40 && o_done !== 1'b1; k++) @(posedge i_ref_clk) #1;
        cmp(o_done, 1'b1);
        if (o_done !== 1'b1) give_verdict();
        cmp(o_busy, 1'b0);
        if (r[1]) cmp(o_success, r[2]);
        // A release write lands one edge after the done pulse
        @(posedge i_ref_clk) #1;
        cmp(o_locked, r[0]);
    endtask : run
    // The read strobe follows the write with no gap
    task automatic acc(input logic [72:0] r);
        @(posedge i_ref_clk);
        {side.wr, side.addr, side.wdata} <= r[72:36];
        @(posedge i_ref_clk);
        {side.wr, side.rd, side.addr} <= {2'h1, r[35:32]};
        @(posedge i_ref_clk);
        side.rd <= 1'b0;
        #1 cmp(side.rdata, r[31:0]);
    endtask : acc
    initial begin
        {side.wr, side.rd, side.addr, side.wdata} = 38'h0;
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        foreach (CMDS[i]) run(CMDS[i]);
        foreach (BUS[i]) acc(BUS[i]);
        cmp({b_flag, b_locked, o_reset_flag}, 3'h1);
        @(posedge i_ref_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_srst <= 1'b0;
        #1 cmp({b_flag, b_locked}, 2'h3);
        acc(BUS[0]);
        run(CMDS[0]);
        give_verdict();
    end
endmodule : tb_top
